// file: rtl/link_ctl_pkg.sv
// Register map, field layout, reset values and timing counts of the serializer link control bank.
package link_ctl_pkg;
	// Register byte offsets.
	localparam logic [7:0] ADDR_GEN_CFG = 8'h03;
	localparam logic [7:0] ADDR_FMT = 8'h05;
	localparam logic [7:0] ADDR_RX_ID = 8'h06;
	localparam logic [7:0] ADDR_RX_ALIAS = 8'h07;
	localparam logic [7:0] ADDR_TGT_ID = 8'h08;
	localparam logic [7:0] ADDR_TGT_ALIAS = 8'h09;
	localparam logic [7:0] ADDR_CRC_LO = 8'h0A;
	localparam logic [7:0] ADDR_CRC_HI = 8'h0B;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_GPO01 = 8'h0D;
	localparam logic [7:0] ADDR_GPO23 = 8'h0E;
	localparam logic [7:0] ADDR_MASTER = 8'h0F;
	localparam logic [7:0] ADDR_PLL_OVR = 8'h35;
	// Reset values of the writable registers.
	localparam logic [7:0] RST_GEN_CFG = 8'hC5;
	localparam logic [7:0] RST_FMT = 8'h00;
	localparam logic [7:0] RST_ID = 8'h00;
	localparam logic [7:0] RST_GPO01 = 8'h55;
	localparam logic [7:0] RST_GPO23 = 8'h35;
	localparam logic [7:0] RST_MASTER = 8'h00;
	localparam logic [7:0] RST_PLL_OVR = 8'h01;
	// Writable bit masks; other bits read back as status or zero.
	localparam logic [7:0] FMT_WMASK = 8'hE3;
	localparam logic [7:0] MASTER_WMASK = 8'h1F;
	localparam logic [7:0] PLL_WMASK = 8'hF3;
	// General configuration fields.
	localparam int CFG_CRC_EN = 7;
	localparam int CFG_PARITY_EN = 6;
	localparam int CFG_CRC_RST = 5;
	localparam int CFG_AUTO_ACK = 4;
	localparam int CFG_PASS_ALL = 3;
	localparam int CFG_PASS_EN = 2;
	localparam int CFG_PLL_OVR = 1;
	localparam int CFG_EDGE = 0;
	// Transmit format fields.
	localparam int FMT_OVR = 5;
	localparam int FMT_CUR = 4;
	localparam int FMT_PIN12 = 3;
	localparam int FMT_PIN10 = 2;
	// Identifier registers keep the freeze flag in bit 0.
	localparam int ID_FREEZE = 0;
	// Per-output nibble fields of the general output registers.
	localparam int GPO_VAL = 3;
	localparam int GPO_REM = 2;
	localparam int GPO_DIR = 1;
	localparam int GPO_EN = 0;
	// Local bus master fields.
	localparam int MST_DLY_LSB = 3;
	localparam int MST_LWD = 2;
	localparam int MST_SPEED = 1;
	localparam int MST_WD_DIS = 0;
	// Clock source override fields.
	localparam int PLL_PIN = 3;
	localparam int PLL_EXT = 1;
	localparam int PLL_OSC = 0;
	// Status fields.
	localparam int ST_REV_LSB = 5;
	localparam int ST_LOCK = 4;
	localparam int ST_BIST = 3;
	localparam int ST_PCLK = 2;
	localparam int ST_DES_ERR = 1;
	localparam int ST_LINK = 0;
	// Revision code; this value is arbitrary.
	localparam logic [2:0] SILICON_REVISION = 3'h5;
	// Clock source encodings driven to the PLL.
	localparam logic [1:0] PLL_SRC_PCLK = 2'h0;
	localparam logic [1:0] PLL_SRC_EXT = 2'h1;
	localparam logic [1:0] PLL_SRC_OSC = 2'h2;
	// Timing, in nanoseconds and in cycles of the 10 MHz clock.
	localparam int CLK_PERIOD_NS = 100;
	localparam int PCLK_LOSS_NS = 2000;
	localparam int PCLK_LOSS_CYC = (PCLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WDOG_LONG_NS = 1000000000;
	localparam int WDOG_LONG_CYC = WDOG_LONG_NS / CLK_PERIOD_NS;
	localparam int WDOG_SHORT_NS = 50000;
	localparam int WDOG_SHORT_CYC = WDOG_SHORT_NS / CLK_PERIOD_NS;
	localparam int RECOVER_HALF_NS = 5000;
	localparam int RECOVER_HALF_CYC = (RECOVER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_PULSES = 9;
endpackage

// file: rtl/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	// Only the second stage is visible to the rest of the block.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_ff <= '0;
			sync_out <= '0;
		end else if (ce_in) begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// file: rtl/bus_watchdog.sv
// Local bus watchdog: idle detection and nine-clock recovery of a stuck bus.
`timescale 1ns/10ps
`default_nettype none
module bus_watchdog
	import link_ctl_pkg::*;
#(
	parameter int LONG_CYC = link_ctl_pkg::WDOG_LONG_CYC,
	parameter int SHORT_CYC = link_ctl_pkg::WDOG_SHORT_CYC,
	parameter int HALF_CYC = link_ctl_pkg::RECOVER_HALF_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic disable_in,
	input wire logic speedup_in,
	output logic bus_free_out,
	output logic scl_oe_out
);
	typedef enum logic [1:0] {
		WD_IDLE = 2'b00,
		WD_LOW = 2'b01,
		WD_HIGH = 2'b11
	} wd_state_t;

	localparam logic [23:0] LIM_LONG = 24'(LONG_CYC - 1);
	localparam logic [23:0] LIM_SHORT = 24'(SHORT_CYC - 1);
	localparam logic [23:0] LIM_HALF = 24'(HALF_CYC - 1);
	localparam logic [3:0] LAST_PULSE = 4'(RECOVER_PULSES - 1);

	wd_state_t state_ff;
	wd_state_t nxt_state;
	logic [23:0] cnt_ff;
	logic [3:0] pulse_ff;
	logic scl_d_ff;
	logic sda_d_ff;

	wire activity = (scl_in != scl_d_ff) || (sda_in != sda_d_ff);
	wire [23:0] limit = speedup_in ? LIM_SHORT : LIM_LONG; // see R20
	wire expired = (cnt_ff == limit) && !disable_in;
	wire half_done = (cnt_ff == LIM_HALF);

	// Idle bus with data high is free; with data low it is recovered by clocking.
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			WD_IDLE: begin
				if (expired && !sda_in) begin
					nxt_state = WD_LOW; // see R21
				end
			end
			WD_LOW: begin
				if (half_done) begin
					nxt_state = WD_HIGH;
				end
			end
			WD_HIGH: begin
				if (half_done) begin
					nxt_state = (pulse_ff == LAST_PULSE) ? WD_IDLE : WD_LOW; // see R21
				end
			end
			default: begin
				nxt_state = WD_IDLE;
			end
		endcase
	end

	// Our own recovery clocks are not counted as bus activity.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= WD_IDLE;
			cnt_ff <= '0;
			pulse_ff <= '0;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
			bus_free_out <= 1'b0;
			scl_oe_out <= 1'b0;
		end else if (ce_in) begin
			state_ff <= nxt_state;
			scl_d_ff <= scl_in;
			sda_d_ff <= sda_in;
			bus_free_out <= (state_ff == WD_IDLE) && expired && sda_in; // see R21
			scl_oe_out <= (nxt_state == WD_LOW);
			if (state_ff == WD_IDLE) begin
				cnt_ff <= (activity || expired || disable_in) ? 24'h000000 : cnt_ff + 24'h000001;
				pulse_ff <= '0;
			end else begin
				cnt_ff <= half_done ? 24'h000000 : cnt_ff + 24'h000001;
				if (state_ff == WD_HIGH && half_done) begin
					pulse_ff <= pulse_ff + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/serializer_link_control_regs.sv
// Control and status register bank of the serializer link, with address routing and output pins.
//
// Operation
// R01 - CRC checker runs only while enabled, reset on
// R02 - Parity generator runs only while enabled, reset on
// R03 - CRC reset bit holds counters clear until zero
// R04 - Auto-acknowledge remote writes when enabled and locked
// R05 - Pass-all forwards foreign addresses, remapped to receiver
// R06 - Alias forwarding only while pass-through enabled
// R07 - Override bit selects PLL source from register
// R08 - Edge select picks rising or falling pixel edge
// R09 - Format override replaces back-channel format; status readable
// R10 - Software sets exactly one format bit when overriding
// R11 - Receiver ID autoloads on lock unless frozen
// R12 - Receiver alias match remaps to receiver ID
// R13 - Target alias match remaps to target ID
// R14 - Sixteen-bit CRC error counter, low then high
// R15 - Status shows lock, self-test error, pixel clock, link
// R16 - Remote error flag sets on CRC error, clears
// R17 - General outputs: enable, remote source, direction
// R18 - Two-bit SDA output delay in 50 ns steps
// R19 - Local write disable rejects control-channel writes
// R20 - Watchdog expires after one second or 50 us
// R21 - Idle frees bus; stuck data gets nine clocks
// R22 - Full digital reset restores all registers
// R23 - CRC counter saturates instead of wrapping
`timescale 1ns/10ps
`default_nettype none
module serializer_link_control_regs #(
	parameter int WDOG_LONG_CYC = link_ctl_pkg::WDOG_LONG_CYC,
	parameter int WDOG_SHORT_CYC = link_ctl_pkg::WDOG_SHORT_CYC,
	parameter int RECOVER_HALF_CYC = link_ctl_pkg::RECOVER_HALF_CYC,
	parameter int PCLK_LOSS_CYC = link_ctl_pkg::PCLK_LOSS_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic soft_reset_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic reg_remote_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output logic reg_wr_rejected_out,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [6:0] req_addr_in,
	input wire logic [6:0] own_id_in,
	output logic fwd_valid_out,
	output logic [6:0] fwd_addr_out,
	output logic fwd_auto_ack_out,
	output logic local_hit_out,
	output logic req_drop_out,
	input wire logic crc_err_in,
	input wire logic bist_mode_in,
	output logic crc_check_en_out,
	output logic parity_gen_en_out,
	input wire logic rx_lock_pin_in,
	input wire logic link_pin_in,
	input wire logic pclk_in,
	input wire logic mode_osc_pin_in,
	input wire logic [1:0] mode_fmt_pin_in,
	input wire logic rx_id_valid_in,
	input wire logic [6:0] rx_id_in,
	input wire logic bc_fmt_valid_in,
	input wire logic [1:0] bc_fmt_in,
	input wire logic [3:0] remote_gpo_in,
	input wire logic general_output_3_pin_in,
	output logic [3:0] gpo_out,
	output logic [3:0] gpo_oe_out,
	output logic general_output_3_sampled_out,
	output logic [1:0] pll_src_out,
	output logic pixel_strobe_out,
	output logic [1:0] tx_format_out,
	output logic [1:0] sda_delay_sel_out,
	input wire logic scl_pin_in,
	input wire logic sda_pin_in,
	output logic scl_out,
	output logic scl_oe_out,
	output logic bus_free_out
);
	import link_ctl_pkg::*;

	// Address compare that treats a zero identifier as a disabled path.
	function automatic logic addr_hit(input logic [6:0] addr, input logic [6:0] id);
		addr_hit = (id != 7'h00) && (addr == id);
	endfunction

	logic [7:0] cfg_ff;
	logic [7:0] fmt_ff;
	logic [7:0] rx_id_ff;
	logic [7:0] rx_alias_ff;
	logic [7:0] tgt_id_ff;
	logic [7:0] tgt_alias_ff;
	logic [7:0] gpo01_ff;
	logic [7:0] gpo23_ff;
	logic [7:0] master_ff;
	logic [7:0] pll_ff;
	logic [15:0] crc_cnt_ff;
	logic des_err_ff;
	logic bist_err_ff;
	logic fmt_cur_ff;
	logic [1:0] bc_fmt_ff;
	logic pclk_d_ff;
	logic pclk_ok_ff;
	logic [7:0] pclk_idle_ff;
	logic [8:0] pins_s;
	logic wd_scl_oe;
	logic wd_bus_free;

	// Every pin from outside this clock domain, pixel clock included, is synchronised first.
	pin_sync #(
		.WIDTH(9)
	) u_pin_sync (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.async_in({rx_lock_pin_in, link_pin_in, pclk_in, mode_osc_pin_in, mode_fmt_pin_in, general_output_3_pin_in,
			scl_pin_in, sda_pin_in}),
		.sync_out(pins_s)
	);

	wire lock_s = pins_s[8];
	wire link_s = pins_s[7];
	wire pclk_s = pins_s[6];
	wire osc_pin_s = pins_s[5];
	wire [1:0] fmt_pin_s = pins_s[4:3];
	wire general_output_3_s = pins_s[2];
	wire scl_s = pins_s[1];
	wire sda_s = pins_s[0];

	// Watchdog on the local bus; its recovery clocks drive the clock pin low.
	bus_watchdog #(
		.LONG_CYC(WDOG_LONG_CYC),
		.SHORT_CYC(WDOG_SHORT_CYC),
		.HALF_CYC(RECOVER_HALF_CYC)
	) u_bus_watchdog (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.scl_in(scl_s),
		.sda_in(sda_s),
		.disable_in(master_ff[MST_WD_DIS]), // see R21
		.speedup_in(master_ff[MST_SPEED]), // see R20
		.bus_free_out(wd_bus_free),
		.scl_oe_out(wd_scl_oe)
	);

	// Register write decode; writes from across the control channel may be locked out.
	wire wr_block = reg_remote_in && master_ff[MST_LWD]; // see R19
	wire wr_ok = reg_wr_in && !wr_block;
	wire wr_cfg = wr_ok && (reg_addr_in == ADDR_GEN_CFG);
	wire wr_fmt = wr_ok && (reg_addr_in == ADDR_FMT);
	wire wr_rx_id = wr_ok && (reg_addr_in == ADDR_RX_ID);
	wire wr_rx_alias = wr_ok && (reg_addr_in == ADDR_RX_ALIAS);
	wire wr_tgt_id = wr_ok && (reg_addr_in == ADDR_TGT_ID);
	wire wr_tgt_alias = wr_ok && (reg_addr_in == ADDR_TGT_ALIAS);
	wire wr_gpo01 = wr_ok && (reg_addr_in == ADDR_GPO01);
	wire wr_gpo23 = wr_ok && (reg_addr_in == ADDR_GPO23);
	wire wr_master = wr_ok && (reg_addr_in == ADDR_MASTER);
	wire wr_pll = wr_ok && (reg_addr_in == ADDR_PLL_OVR);

	// Read-only views assembled from live state.
	wire [7:0] status_view = {SILICON_REVISION, lock_s, bist_err_ff, pclk_ok_ff, des_err_ff, link_s}; // see R15
	wire [7:0] fmt_view = (fmt_ff & FMT_WMASK) | {3'h0, fmt_cur_ff, fmt_pin_s[1], fmt_pin_s[0], 2'h0}; // see R09
	wire [7:0] pll_view = (pll_ff & PLL_WMASK) | {4'h0, osc_pin_s, 3'h0};
	wire [7:0] rd_mux = (reg_addr_in == ADDR_GEN_CFG) ? cfg_ff :
		(reg_addr_in == ADDR_FMT) ? fmt_view :
		(reg_addr_in == ADDR_RX_ID) ? rx_id_ff :
		(reg_addr_in == ADDR_RX_ALIAS) ? rx_alias_ff :
		(reg_addr_in == ADDR_TGT_ID) ? tgt_id_ff :
		(reg_addr_in == ADDR_TGT_ALIAS) ? tgt_alias_ff :
		(reg_addr_in == ADDR_CRC_LO) ? crc_cnt_ff[7:0] : // see R14
		(reg_addr_in == ADDR_CRC_HI) ? crc_cnt_ff[15:8] : // see R14
		(reg_addr_in == ADDR_STATUS) ? status_view :
		(reg_addr_in == ADDR_GPO01) ? gpo01_ff :
		(reg_addr_in == ADDR_GPO23) ? gpo23_ff :
		(reg_addr_in == ADDR_MASTER) ? (master_ff & MASTER_WMASK) :
		(reg_addr_in == ADDR_PLL_OVR) ? pll_view : 8'h00;

	// Read data is registered one cycle after the strobe.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
			reg_wr_rejected_out <= 1'b0;
		end else if (ce_in) begin
			reg_rvalid_out <= reg_rd_in;
			reg_rdata_out <= reg_rd_in ? rd_mux : reg_rdata_out;
			reg_wr_rejected_out <= reg_wr_in && wr_block; // see R19
		end
	end

	// Configuration registers; the soft digital reset returns them all to defaults.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_ff <= RST_GEN_CFG;
			fmt_ff <= RST_FMT;
			rx_alias_ff <= RST_ID;
			tgt_id_ff <= RST_ID;
			tgt_alias_ff <= RST_ID;
			gpo01_ff <= RST_GPO01;
			gpo23_ff <= RST_GPO23;
			master_ff <= RST_MASTER;
			pll_ff <= RST_PLL_OVR;
		end else if (ce_in) begin
			if (soft_reset_in) begin
				cfg_ff <= RST_GEN_CFG; // see R22
				fmt_ff <= RST_FMT;
				rx_alias_ff <= RST_ID;
				tgt_id_ff <= RST_ID;
				tgt_alias_ff <= RST_ID;
				gpo01_ff <= RST_GPO01;
				gpo23_ff <= RST_GPO23;
				master_ff <= RST_MASTER;
				pll_ff <= RST_PLL_OVR;
			end else begin
				cfg_ff <= wr_cfg ? reg_wdata_in : cfg_ff;
				fmt_ff <= wr_fmt ? (reg_wdata_in & FMT_WMASK) : fmt_ff;
				rx_alias_ff <= wr_rx_alias ? reg_wdata_in : rx_alias_ff;
				tgt_id_ff <= wr_tgt_id ? reg_wdata_in : tgt_id_ff;
				tgt_alias_ff <= wr_tgt_alias ? reg_wdata_in : tgt_alias_ff;
				gpo01_ff <= wr_gpo01 ? reg_wdata_in : gpo01_ff;
				gpo23_ff <= wr_gpo23 ? reg_wdata_in : gpo23_ff;
				master_ff <= wr_master ? (reg_wdata_in & MASTER_WMASK) : master_ff;
				pll_ff <= wr_pll ? (reg_wdata_in & PLL_WMASK) : pll_ff;
			end
		end
	end

	// Receiver ID: software write first, else the control channel loads it after lock.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_id_ff <= RST_ID;
		end else if (ce_in) begin
			if (soft_reset_in) begin
				rx_id_ff <= RST_ID; // see R22
			end else if (wr_rx_id) begin
				rx_id_ff <= reg_wdata_in;
			end else if (rx_id_valid_in && lock_s && !rx_id_ff[ID_FREEZE]) begin
				rx_id_ff <= {rx_id_in, rx_id_ff[ID_FREEZE]}; // see R11
			end
		end
	end

	// Error accounting. The clear bit is a level, so counters stay at zero while it is held.
	wire crc_rst = cfg_ff[CFG_CRC_RST];
	wire crc_seen = crc_err_in && cfg_ff[CFG_CRC_EN]; // see R01
	wire crc_normal = crc_seen && !bist_mode_in;
	wire crc_bist = crc_seen && bist_mode_in;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			crc_cnt_ff <= 16'h0000;
			des_err_ff <= 1'b0;
			bist_err_ff <= 1'b0;
		end else if (ce_in) begin
			if (soft_reset_in || crc_rst) begin
				crc_cnt_ff <= 16'h0000; // see R03
			end else if (crc_normal && crc_cnt_ff != 16'hFFFF) begin
				crc_cnt_ff <= crc_cnt_ff + 16'h0001; // see R14, R23
			end
			// A new error wins over a clear in the same cycle.
			des_err_ff <= crc_normal || (des_err_ff && link_s && !crc_rst && !soft_reset_in); // see R16
			bist_err_ff <= crc_bist || (bist_err_ff && !crc_rst && !soft_reset_in); // see R15
		end
	end

	// Transmit format from the back channel, or from software when overridden.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bc_fmt_ff <= 2'h0;
			fmt_cur_ff <= 1'b0;
			tx_format_out <= 2'h0;
		end else if (ce_in) begin
			bc_fmt_ff <= bc_fmt_valid_in ? bc_fmt_in : bc_fmt_ff;
			fmt_cur_ff <= bc_fmt_valid_in || (fmt_cur_ff && lock_s && !soft_reset_in); // see R09
			// Only one bit may be set when overriding; the pair is passed on as written.
			tx_format_out <= fmt_ff[FMT_OVR] ? fmt_ff[1:0] : bc_fmt_ff; // see R09, R10
		end
	end

	// Pixel clock edge detection and loss timeout, both on the synchronised copy.
	wire pclk_rise = pclk_s && !pclk_d_ff;
	wire pclk_fall = !pclk_s && pclk_d_ff;
	localparam logic [7:0] PCLK_LIMIT = 8'(PCLK_LOSS_CYC);

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pclk_d_ff <= 1'b0;
			pclk_idle_ff <= 8'h00;
			pclk_ok_ff <= 1'b0;
			pixel_strobe_out <= 1'b0;
		end else if (ce_in) begin
			pclk_d_ff <= pclk_s;
			pixel_strobe_out <= cfg_ff[CFG_EDGE] ? pclk_rise : pclk_fall; // see R08
			if (pclk_rise) begin
				pclk_idle_ff <= 8'h00;
				pclk_ok_ff <= 1'b1; // see R15
			end else if (pclk_idle_ff == PCLK_LIMIT) begin
				pclk_ok_ff <= 1'b0;
			end else begin
				pclk_idle_ff <= pclk_idle_ff + 8'h01;
			end
		end
	end

	// Address routing of local bus requests toward the remote side.
	wire [6:0] rx_id = rx_id_ff[7:1];
	wire [6:0] tgt_id = tgt_id_ff[7:1];
	wire pass_en = cfg_ff[CFG_PASS_EN];
	wire pass_all = cfg_ff[CFG_PASS_ALL];
	wire own_hit = (req_addr_in == own_id_in);
	wire rx_alias_hit = addr_hit(req_addr_in, rx_alias_ff[7:1]) && (rx_id != 7'h00); // see R12
	wire tgt_alias_hit = addr_hit(req_addr_in, tgt_alias_ff[7:1]) && (tgt_id != 7'h00); // see R13
	wire rx_direct = addr_hit(req_addr_in, rx_id); // see R11
	wire tgt_direct = addr_hit(req_addr_in, tgt_id);
	wire to_receiver = rx_alias_hit || rx_direct || (pass_all && rx_id != 7'h00); // see R05
	wire fwd = pass_en && !own_hit && (to_receiver || tgt_alias_hit || tgt_direct); // see R06
	wire [6:0] fwd_addr = tgt_alias_hit ? tgt_id : (rx_alias_hit || rx_direct || pass_all) ? rx_id : req_addr_in;
	wire auto_ack = req_write_in && cfg_ff[CFG_AUTO_ACK] && lock_s && to_receiver; // see R04

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fwd_valid_out <= 1'b0;
			fwd_addr_out <= 7'h00;
			fwd_auto_ack_out <= 1'b0;
			local_hit_out <= 1'b0;
			req_drop_out <= 1'b0;
		end else if (ce_in) begin
			fwd_valid_out <= req_valid_in && fwd;
			fwd_addr_out <= (req_valid_in && fwd) ? fwd_addr : fwd_addr_out; // see R05, R12, R13
			fwd_auto_ack_out <= req_valid_in && fwd && auto_ack; // see R04
			local_hit_out <= req_valid_in && own_hit;
			req_drop_out <= req_valid_in && !own_hit && !fwd;
		end
	end

	// General output nibbles, one per pin; only the fourth has a direction bit.
	wire [3:0] gpo_cfg [4];
	assign gpo_cfg[0] = gpo01_ff[3:0];
	assign gpo_cfg[1] = gpo01_ff[7:4];
	assign gpo_cfg[2] = gpo23_ff[3:0];
	assign gpo_cfg[3] = gpo23_ff[7:4];

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gpo_out <= 4'h0;
			gpo_oe_out <= 4'h0;
		end else if (ce_in) begin
			for (int i = 0; i < 4; i++) begin
				gpo_out[i] <= gpo_cfg[i][GPO_REM] ? remote_gpo_in[i] : gpo_cfg[i][GPO_VAL]; // see R17
				gpo_oe_out[i] <= gpo_cfg[i][GPO_EN] && !(i == 3 && gpo_cfg[i][GPO_DIR]); // see R17
			end
		end
	end

	// Remaining registered outputs: enables, clock source, delay select and the bus pin.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			crc_check_en_out <= 1'b1;
			parity_gen_en_out <= 1'b1;
			pll_src_out <= PLL_SRC_PCLK;
			sda_delay_sel_out <= 2'h0;
			general_output_3_sampled_out <= 1'b0;
			scl_out <= 1'b0;
			scl_oe_out <= 1'b0;
			bus_free_out <= 1'b0;
		end else if (ce_in) begin
			crc_check_en_out <= cfg_ff[CFG_CRC_EN]; // see R01
			parity_gen_en_out <= cfg_ff[CFG_PARITY_EN]; // see R02
			if (cfg_ff[CFG_PLL_OVR]) begin
				pll_src_out <= pll_ff[PLL_OSC] ? PLL_SRC_OSC : pll_ff[PLL_EXT] ? PLL_SRC_EXT : PLL_SRC_PCLK; // see R07
			end else begin
				pll_src_out <= osc_pin_s ? PLL_SRC_EXT : PLL_SRC_PCLK; // see R07
			end
			// The delay itself is produced by the bus pad logic; this only selects the step.
			sda_delay_sel_out <= master_ff[MST_DLY_LSB+1:MST_DLY_LSB]; // see R18
			general_output_3_sampled_out <= general_output_3_s;
			scl_out <= 1'b0;
			scl_oe_out <= wd_scl_oe; // see R21
			bus_free_out <= wd_bus_free;
		end
	end
endmodule
`default_nettype wire

// file: verification/link_ctl_asserts.sv
// Port checks of the link control register bank.
`timescale 1ns/10ps
`default_nettype none
module link_ctl_asserts (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic reg_rd_in,
	input wire logic reg_wr_in,
	input wire logic reg_remote_in,
	input wire logic reg_rvalid_out,
	input wire logic reg_wr_rejected_out,
	input wire logic req_valid_in,
	input wire logic fwd_valid_out,
	input wire logic fwd_auto_ack_out,
	input wire logic local_hit_out,
	input wire logic req_drop_out
);
	// One clock domain, so clocking and reset are given once.
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	rd_answer_a: assert property (ce_in && reg_rd_in |=> reg_rvalid_out)
		else $error("read unanswered");
	rd_quiet_a: assert property (ce_in && !reg_rd_in |=> !reg_rvalid_out)
		else $error("stray read answer");
	reject_cause_a: assert property (reg_wr_rejected_out |-> $past(reg_wr_in && reg_remote_in))
		else $error("reject without remote write");
	local_wr_a: assert property (ce_in && reg_wr_in && !reg_remote_in |=> !reg_wr_rejected_out)
		else $error("local write rejected");
	route_one_a: assert property (ce_in && req_valid_in |=> $onehot({local_hit_out, fwd_valid_out, req_drop_out}))
		else $error("routing not exactly one");
	route_cause_a: assert property (fwd_valid_out || local_hit_out |-> $past(req_valid_in))
		else $error("routing without request");
	ack_fwd_a: assert property (fwd_auto_ack_out |-> fwd_valid_out)
		else $error("ack without forward");
	idle_route_a: assert property (!req_valid_in |=> !req_drop_out)
		else $error("drop without request");
	c_rej: cover property (reg_wr_rejected_out);
	c_fwd: cover property (fwd_valid_out);
	c_hit: cover property (local_hit_out);
endmodule
bind serializer_link_control_regs link_ctl_asserts link_ctl_asserts_i (.*);
`default_nettype wire

// file: verification/link_peer_model.sv
// Far side of the link: pixel clock, lock and cable pins.
`timescale 1ns/10ps
`default_nettype none
module link_peer_model (
	input wire logic run_in,
	output var logic pclk_out,
	output logic lock_out,
	output logic link_out
);
	// The pixel clock stands still while the peer is idle.
	initial pclk_out = 1'b0;
	always #400 pclk_out = run_in ? ~pclk_out : 1'b0;
	assign lock_out = run_in;
	assign link_out = run_in;
endmodule
`default_nettype wire

// file: verification/serializer_link_control_regs_tb.sv
// Self-checking bench of the link control register bank.
`timescale 1ns/10ps
`default_nettype none
module serializer_link_control_regs_tb;
	import link_ctl_pkg::*;
	logic mclk_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0, rem = 1'b0, qv = 1'b0, crc = 1'b0, run = 1'b0;
	logic rv, rej, fv, hit, drop, cen, pclk, lock, link, aa;
	logic [7:0] adr = 8'h00, wd = 8'h00, rdata, sb = 8'h00;
	logic [6:0] qa = 7'h00, fa;
	logic [1:0] fmt;
	int n_mismatch = 0, tests_run = 0;
	// Register offsets probed after reset, with their documented reset bytes.
	logic [7:0] ra [7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h0D, 8'h0E, 8'h0F};
	logic [7:0] re [7] = '{8'hC5, 8'h00, 8'h00, 8'h00, 8'h55, 8'h35, 8'h00};
	// The clock toggles each half period.
	always #50 mclk_in = ~mclk_in;
	link_peer_model link_peer_model_i (.run_in(run), .pclk_out(pclk), .lock_out(lock), .link_out(link));
	serializer_link_control_regs #(.WDOG_LONG_CYC(2000), .RECOVER_HALF_CYC(4)) serializer_link_control_regs_i (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(!sb[7]), .soft_reset_in(sb[0]), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_remote_in(rem), .reg_addr_in(adr), .reg_wdata_in(wd), .reg_rdata_out(rdata),
		.reg_rvalid_out(rv), .reg_wr_rejected_out(rej), .req_valid_in(qv), .req_write_in(!sb[6]),
		.req_addr_in(qa), .own_id_in(7'h2C), .fwd_valid_out(fv), .fwd_addr_out(fa), .fwd_auto_ack_out(aa),
		.local_hit_out(hit), .req_drop_out(drop), .crc_err_in(crc), .bist_mode_in(sb[1]), .crc_check_en_out(cen),
		.parity_gen_en_out(), .rx_lock_pin_in(lock), .link_pin_in(link), .pclk_in(pclk), .mode_osc_pin_in(sb[2]),
		.mode_fmt_pin_in(sb[5:4]), .rx_id_valid_in(sb[3]), .rx_id_in(qa), .bc_fmt_valid_in(sb[4]),
		.bc_fmt_in(wd[1:0]), .remote_gpo_in(4'h0), .general_output_3_pin_in(sb[5]),
		.gpo_out(), .gpo_oe_out(), .general_output_3_sampled_out(), .pll_src_out(), .pixel_strobe_out(), .tx_format_out(fmt),
		.sda_delay_sel_out(), .scl_pin_in(1'b1), .sda_pin_in(1'b1), .scl_out(), .scl_oe_out(), .bus_free_out());
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	// Strobes rise after a falling edge and drop one cycle later.
	task automatic wreg(input logic [7:0] a, input logic [7:0] d, input logic r);
		@(negedge mclk_in);
		{wr, adr, wd, rem} = {1'b1, a, d, r};
		@(negedge mclk_in);
		wr = 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk_in);
		{rd, adr} = {1'b1, a};
		@(negedge mclk_in);
		rd = 1'b0;
		chk({rv, rdata}, {1'b1, e});
	endtask
	task automatic route(input logic [6:0] a, input logic [2:0] e, input logic [6:0] ea);
		@(negedge mclk_in);
		{qv, qa} = {1'b1, a};
		@(negedge mclk_in);
		qv = 1'b0;
		chk({hit, fv, drop, e[1] ? fa : 7'h00}, {e, ea});
	endtask
	task automatic errs(input int n);
		repeat (n) begin
			@(negedge mclk_in) crc = 1'b1;
			@(negedge mclk_in) crc = 1'b0;
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// A hung run is cut short and counted as a mismatch.
	initial begin
		#3000000;
		n_mismatch++;
		tally_and_finish();
	end
	// Main sequence: reset, then one scenario per behaviour.
	initial begin
		repeat (3) @(negedge mclk_in);
		{rst_n_in, run} = 2'b11;
		foreach (ra[i]) rreg(ra[i], re[i]);
		chk(cen, 1'b1);
		repeat (30) @(negedge mclk_in);
		rreg(8'h0C, {SILICON_REVISION, 5'h15});
		errs(3);
		rreg(8'h0A, 8'h03);
		rreg(8'h0B, 8'h00);
		rreg(8'h0C, {SILICON_REVISION, 5'h17});
		wreg(8'h03, 8'hE5, 1'b0);
		rreg(8'h0A, 8'h00);
		rreg(8'h0C, {SILICON_REVISION, 5'h15});
		wreg(8'h03, 8'h45, 1'b0);
		errs(2);
		chk(cen, 1'b0);
		rreg(8'h0A, 8'h00);
		wreg(8'h0F, 8'h04, 1'b0);
		wreg(8'h06, 8'hAA, 1'b1);
		rreg(8'h06, 8'h00);
		wreg(8'h0F, 8'h00, 1'b0);
		wreg(8'h06, 8'h61, 1'b0);
		wreg(8'h07, 8'h40, 1'b0);
		wreg(8'h03, 8'hC5, 1'b0);
		route(7'h20, 3'b010, 7'h30);
		route(7'h2C, 3'b100, 7'h00);
		route(7'h11, 3'b001, 7'h00);
		wreg(8'h03, 8'hCD, 1'b0);
		route(7'h11, 3'b010, 7'h30);
		wreg(8'h03, 8'hC1, 1'b0);
		route(7'h20, 3'b001, 7'h00);
		wreg(8'h05, 8'h22, 1'b0);
		@(negedge mclk_in);
		chk(fmt, 2'b10);
		rreg(8'h05, 8'h22);
		// A write during a frozen clock enable must not land.
		@(negedge mclk_in) sb[7] = 1'b1;
		wreg(8'h0F, 8'h18, 1'b0);
		sb[7] = 1'b0;
		rreg(8'h0F, 8'h00);
		@(negedge mclk_in) sb[0] = 1'b1;
		@(negedge mclk_in) sb[0] = 1'b0;
		rreg(8'h03, 8'hC5);
		{sb[3], qa} = {1'b1, 7'h3A};
		@(negedge mclk_in) sb[3] = 1'b0;
		rreg(8'h06, 8'h74);
		wreg(8'h03, 8'hD5, 1'b0);
		route(7'h3A, 3'b010, 7'h3A);
		chk(aa, 1'b1);
		sb[1] = 1'b1;
		errs(1);
		rreg(8'h0C, {SILICON_REVISION, 5'h1D});
		rreg(8'h0A, 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
